// [design/vrsc_defs.vh]
`ifndef VRSC_DEFS_VH
`define VRSC_DEFS_VH

// Register byte offsets on the APB slave.
`define VRSC_REF_CTRL_OFF 12'h000
`define VRSC_AUX_CTRL_OFF 12'h004
`define VRSC_FIXED_CTRL_OFF 12'h008
`define VRSC_ADC_CFG_OFF 12'h00C
`define VRSC_STATUS_OFF 12'h010

// Reset values.
`define VRSC_REF_CTRL_RST 8'h00
`define VRSC_AUX_CTRL_RST 8'h00
`define VRSC_FIXED_CTRL_RST 8'h00
`define VRSC_ADC_CFG_RST 8'h00

// Field positions in ref_voltage_control.
`define VRSC_POWER_BIT 7
`define VRSC_PIN_OE_BIT 6
`define VRSC_RANGE_LOW_BIT 5
`define VRSC_SRC_EXT_BIT 4
`define VRSC_TAP_MSB 3
`define VRSC_TAP_LSB 0

// Field positions in comparator_aux_control.
`define VRSC_CMP1_SEL_BIT 5
`define VRSC_CMP2_SEL_BIT 4

// Field position in latch_and_fixed_control.
`define VRSC_FIXED_EN_BIT 0

// Field positions in the ADC reference configuration register.
`define VRSC_ADC_POS_BIT 0
`define VRSC_ADC_NEG_BIT 1

// Field positions in the status register.
`define VRSC_ST_CMP1_BIT 0
`define VRSC_ST_CMP2_BIT 1
`define VRSC_ST_OSC_BIT 2
`define VRSC_ST_FIXED_ON_BIT 3
`define VRSC_ST_CURRENT_BIT 4

// Ladder tap arithmetic: output is numerator / denominator of the ladder supply.
`define VRSC_LOW_DENOM 6'h18
`define VRSC_HIGH_DENOM 6'h20
`define VRSC_HIGH_BASE 6'h08

// Function codes of port A pin two.
`define VRSC_PIN2_IO 2'h0
`define VRSC_PIN2_ADJ_REF 2'h1
`define VRSC_PIN2_EXT_NEG 2'h2

`endif

// [design/vrsc_route_dec.v]
`timescale 1ns/1ns
`include "vrsc_defs.vh"

// Source-priority decode for comparator and ADC references and pin functions.
module vrsc_route_dec
(
    input wire src_external,
    input wire pin_out_en,
    input wire adc_pos_cfg,
    input wire adc_neg_cfg,
    output reg cmp_pos_ext,
    output reg cmp_neg_ext,
    output reg adc_pos_ext,
    output reg adc_neg_ext,
    output reg [1:0] pin_two_func,
    output reg pin_three_ext
);

always @*
begin
    // R15 comparator reference routing
    cmp_pos_ext = src_external;
    cmp_neg_ext = src_external & (adc_neg_cfg | ~pin_out_en);
    // R16 ADC reference routing
    adc_pos_ext = adc_pos_cfg;
    adc_neg_ext = adc_neg_cfg;
    // R17 pin two function
    if (adc_neg_cfg || (src_external && !pin_out_en))
        pin_two_func = `VRSC_PIN2_EXT_NEG;
    else if (pin_out_en)
        pin_two_func = `VRSC_PIN2_ADJ_REF;
    else
        pin_two_func = `VRSC_PIN2_IO;
    // R18 pin three function
    pin_three_ext = adc_pos_cfg | src_external;
end

endmodule // vrsc_route_dec

// [design/vrsc_sync.v]
`timescale 1ns/1ns

// Two-stage synchroniser for levels arriving from outside the pclk domain.
module vrsc_sync
#(
    parameter WIDTH = 1
)
(
    input wire pclk,
    input wire presetn,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] stage1_reg;
reg [WIDTH-1:0] stage2_reg;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        stage1_reg <= {WIDTH{1'b0}};
        stage2_reg <= {WIDTH{1'b0}};
    end
    else
    begin
        stage1_reg <= async_in;
        stage2_reg <= stage1_reg;
    end
end

assign sync_out = stage2_reg;

endmodule // vrsc_sync

// [design/vrsc_top.v]
// Contract
// R1: Ladder powered while the power enable bit is set, down when clear.
// R2: No comparator setting alters ladder enable, range or tap.
// R3: Range bit one picks low range, zero picks high range.
// R4: Four-bit tap code from low bits, sixteen levels, values 0 to 15.
// R5: Low range output is tap code over 24 of ladder supply.
// R6: High range output is quarter supply plus tap code over 32.
// R7: Source bit one feeds ladder from external pins, zero from rails.
// R8: Output enable bit connects the adjustable reference to port A pin two.
// R9: Fixed reference on when its enable is set or fast oscillator runs.
// R10: Fixed enable clear clamps adjustable output to ground, no ladder current.
// R11: Software waits for settling after enabling fixed reference; no ready flag.
// R12: Comparator 1 select picks adjustable reference and ladder current, else fixed.
// R13: Comparator 2 select picks adjustable reference and ladder current, else fixed.
// R14: Ladder current enable equals OR of both comparator select bits; the code also ANDs it with the fixed enable bit.
// R15: Comparator references follow source bit, negative also needs cfg or no pin.
// R16: ADC references follow ADC config bits only.
// R17: Pin two is external negative, adjustable output, or general I/O.
// R18: Pin three is external positive when ADC bit 0 or source set.
// R19: Control bits reset to zero, read-write, act after the write edge.
// R20: Comparator status bits show actual comparator results, not pin levels.
`timescale 1ns/1ns
`include "vrsc_defs.vh"

module vrsc_top
#(
    parameter TAP_WIDTH = 4
)
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire fast_internal_oscillator,
    input wire cmp1_result,
    input wire cmp2_result,
    output reg ladder_power_enable,
    output reg ladder_pin_output_enable,
    output reg ladder_range_low,
    output reg ladder_source_external,
    output reg [TAP_WIDTH-1:0] ladder_tap_code,
    output reg [5:0] ladder_tap_numerator,
    output reg [5:0] ladder_tap_denominator,
    output reg ladder_current_enable,
    output reg adjustable_reference_clamp,
    output reg fixed_reference_on,
    output reg cmp1_adjustable_route,
    output reg cmp2_adjustable_route,
    output reg cmp_pos_ref_external,
    output reg cmp_neg_ref_external,
    output reg adc_pos_ref_external,
    output reg adc_neg_ref_external,
    output reg [1:0] port_a_pin_two_func,
    output reg port_a_pin_three_ext_pos
);

reg [7:0] ref_voltage_control_reg;
reg [7:0] comparator_aux_control_reg;
reg [7:0] latch_and_fixed_control_reg;
reg [7:0] adc_ref_cfg_reg;
reg [7:0] ref_voltage_control_next;
reg [7:0] comparator_aux_control_next;
reg [7:0] latch_and_fixed_control_next;
reg [7:0] adc_ref_cfg_next;
reg [31:0] rdata_next;
reg addr_hit;

wire setup_phase;
wire access_done;
wire wr_access;
wire osc_active;
wire [1:0] cmp_results;
wire ladder_power_en;
wire pin_out_en;
wire range_low;
wire src_external;
wire [TAP_WIDTH-1:0] tap_code;
wire cmp1_sel;
wire cmp2_sel;
wire fixed_en;
wire adc_pos_cfg;
wire adc_neg_cfg;
wire [7:0] status_word;
wire dec_cmp_pos_ext;
wire dec_cmp_neg_ext;
wire dec_adc_pos_ext;
wire dec_adc_neg_ext;
wire [1:0] dec_pin_two_func;
wire dec_pin_three_ext;
wire [5:0] tap_ext;

// The oscillator flag and comparator outputs come from other domains.
vrsc_sync
#(
    .WIDTH(1)
)
u_osc_sync
(
    .pclk(pclk),
    .presetn(presetn),
    .async_in(fast_internal_oscillator),
    .sync_out(osc_active)
);

// R20 raw comparator results
vrsc_sync
#(
    .WIDTH(2)
)
u_cmp_sync
(
    .pclk(pclk),
    .presetn(presetn),
    .async_in({cmp2_result, cmp1_result}),
    .sync_out(cmp_results)
);

assign setup_phase = psel & ~penable;
assign access_done = psel & penable & pready;
assign wr_access = access_done & pwrite & ~pslverr;

// R2 ladder fields only from own register
assign ladder_power_en = ref_voltage_control_reg[`VRSC_POWER_BIT];
assign pin_out_en = ref_voltage_control_reg[`VRSC_PIN_OE_BIT];
assign range_low = ref_voltage_control_reg[`VRSC_RANGE_LOW_BIT];
assign src_external = ref_voltage_control_reg[`VRSC_SRC_EXT_BIT];
// R4 tap code field
assign tap_code = ref_voltage_control_reg[`VRSC_TAP_MSB:`VRSC_TAP_LSB];
assign tap_ext = {{(6-TAP_WIDTH){1'b0}}, tap_code};
assign cmp1_sel = comparator_aux_control_reg[`VRSC_CMP1_SEL_BIT];
assign cmp2_sel = comparator_aux_control_reg[`VRSC_CMP2_SEL_BIT];
assign fixed_en = latch_and_fixed_control_reg[`VRSC_FIXED_EN_BIT];
assign adc_pos_cfg = adc_ref_cfg_reg[`VRSC_ADC_POS_BIT];
assign adc_neg_cfg = adc_ref_cfg_reg[`VRSC_ADC_NEG_BIT];

// R20 status from actual results
assign status_word = {3'h0,
                      ladder_current_enable,
                      fixed_reference_on,
                      osc_active,
                      cmp_results[1],
                      cmp_results[0]};

vrsc_route_dec u_route_dec
(
    .src_external(src_external),
    .pin_out_en(pin_out_en),
    .adc_pos_cfg(adc_pos_cfg),
    .adc_neg_cfg(adc_neg_cfg),
    .cmp_pos_ext(dec_cmp_pos_ext),
    .cmp_neg_ext(dec_cmp_neg_ext),
    .adc_pos_ext(dec_adc_pos_ext),
    .adc_neg_ext(dec_adc_neg_ext),
    .pin_two_func(dec_pin_two_func),
    .pin_three_ext(dec_pin_three_ext)
);

// Read data and the error answer are prepared in the setup phase, so the
// access phase always completes in its first cycle.
always @*
begin
    addr_hit = 1'b1;
    rdata_next = 32'h00000000;
    case (paddr)
        `VRSC_REF_CTRL_OFF:
            rdata_next = {24'h000000, ref_voltage_control_reg};
        `VRSC_AUX_CTRL_OFF:
            rdata_next = {24'h000000, comparator_aux_control_reg};
        `VRSC_FIXED_CTRL_OFF:
            rdata_next = {24'h000000, latch_and_fixed_control_reg};
        `VRSC_ADC_CFG_OFF:
            rdata_next = {24'h000000, adc_ref_cfg_reg};
        `VRSC_STATUS_OFF:
            rdata_next = {24'h000000, status_word};
        default:
            addr_hit = 1'b0;
    endcase
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end
    else
    begin
        pready <= setup_phase;
        pslverr <= setup_phase & ~addr_hit;
        if (setup_phase && !pwrite)
            prdata <= rdata_next;
    end
end

// Only implemented bits are writable; the rest read as zero.
always @*
begin
    ref_voltage_control_next = ref_voltage_control_reg;
    comparator_aux_control_next = comparator_aux_control_reg;
    latch_and_fixed_control_next = latch_and_fixed_control_reg;
    adc_ref_cfg_next = adc_ref_cfg_reg;
    if (wr_access)
    begin
        case (paddr)
            `VRSC_REF_CTRL_OFF:
                ref_voltage_control_next = pwdata[7:0];
            `VRSC_AUX_CTRL_OFF:
            begin
                comparator_aux_control_next = 8'h00;
                comparator_aux_control_next[`VRSC_CMP1_SEL_BIT] =
                    pwdata[`VRSC_CMP1_SEL_BIT];
                comparator_aux_control_next[`VRSC_CMP2_SEL_BIT] =
                    pwdata[`VRSC_CMP2_SEL_BIT];
            end
            `VRSC_FIXED_CTRL_OFF:
            begin
                latch_and_fixed_control_next = 8'h00;
                latch_and_fixed_control_next[`VRSC_FIXED_EN_BIT] =
                    pwdata[`VRSC_FIXED_EN_BIT];
            end
            `VRSC_ADC_CFG_OFF:
            begin
                adc_ref_cfg_next = 8'h00;
                adc_ref_cfg_next[`VRSC_ADC_POS_BIT] = pwdata[`VRSC_ADC_POS_BIT];
                adc_ref_cfg_next[`VRSC_ADC_NEG_BIT] = pwdata[`VRSC_ADC_NEG_BIT];
            end
            default:
                ref_voltage_control_next = ref_voltage_control_reg;
        endcase
    end
end

// R19 reset and write update
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        ref_voltage_control_reg <= `VRSC_REF_CTRL_RST;
        comparator_aux_control_reg <= `VRSC_AUX_CTRL_RST;
        latch_and_fixed_control_reg <= `VRSC_FIXED_CTRL_RST;
        adc_ref_cfg_reg <= `VRSC_ADC_CFG_RST;
    end
    else
    begin
        ref_voltage_control_reg <= ref_voltage_control_next;
        comparator_aux_control_reg <= comparator_aux_control_next;
        latch_and_fixed_control_reg <= latch_and_fixed_control_next;
        adc_ref_cfg_reg <= adc_ref_cfg_next;
    end
end

// Every control output is registered once more, so the analog side sees a
// change one edge after the register itself changes.
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        ladder_power_enable <= 1'b0;
        ladder_pin_output_enable <= 1'b0;
        ladder_range_low <= 1'b0;
        ladder_source_external <= 1'b0;
        ladder_tap_code <= {TAP_WIDTH{1'b0}};
        ladder_tap_numerator <= `VRSC_HIGH_BASE;
        ladder_tap_denominator <= `VRSC_HIGH_DENOM;
    end
    else
    begin
        // R1 ladder power
        ladder_power_enable <= ladder_power_en;
        // R8 pin output connect
        ladder_pin_output_enable <= pin_out_en;
        // R3 range select
        ladder_range_low <= range_low;
        // R7 ladder source
        ladder_source_external <= src_external;
        ladder_tap_code <= tap_code;
        if (range_low)
        begin
            // R5 low range tap
            ladder_tap_numerator <= tap_ext;
            ladder_tap_denominator <= `VRSC_LOW_DENOM;
        end
        else
        begin
            // R6 high range tap
            ladder_tap_numerator <= `VRSC_HIGH_BASE + tap_ext;
            ladder_tap_denominator <= `VRSC_HIGH_DENOM;
        end
    end
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        ladder_current_enable <= 1'b0;
        adjustable_reference_clamp <= 1'b1;
        fixed_reference_on <= 1'b0;
        cmp1_adjustable_route <= 1'b0;
        cmp2_adjustable_route <= 1'b0;
    end
    else
    begin
        // R14 ladder current
        ladder_current_enable <= (cmp1_sel | cmp2_sel) & fixed_en;
        // R10 clamp to ground
        adjustable_reference_clamp <= ~fixed_en;
        // R9 fixed reference on
        fixed_reference_on <= fixed_en | osc_active;
        // R12 comparator 1 route
        cmp1_adjustable_route <= cmp1_sel;
        // R13 comparator 2 route
        cmp2_adjustable_route <= cmp2_sel;
    end
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        cmp_pos_ref_external <= 1'b0;
        cmp_neg_ref_external <= 1'b0;
        adc_pos_ref_external <= 1'b0;
        adc_neg_ref_external <= 1'b0;
        port_a_pin_two_func <= `VRSC_PIN2_IO;
        port_a_pin_three_ext_pos <= 1'b0;
    end
    else
    begin
        // R15 comparator references
        cmp_pos_ref_external <= dec_cmp_pos_ext;
        cmp_neg_ref_external <= dec_cmp_neg_ext;
        // R16 ADC references
        adc_pos_ref_external <= dec_adc_pos_ext;
        adc_neg_ref_external <= dec_adc_neg_ext;
        // R17 pin two function
        port_a_pin_two_func <= dec_pin_two_func;
        // R18 pin three function
        port_a_pin_three_ext_pos <= dec_pin_three_ext;
    end
end

endmodule // vrsc_top

// [verification/voltage_ref_select_ctrl_tb.sv]
`timescale 1ns/1ns

module voltage_ref_select_ctrl_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic fast_internal_oscillator, cmp1_result, cmp2_result, osc_req = 0;
    logic ladder_power_enable, ladder_pin_output_enable, ladder_range_low, ladder_source_external;
    logic ladder_current_enable, adjustable_reference_clamp, fixed_reference_on;
    logic cmp1_adjustable_route, cmp2_adjustable_route, cmp_pos_ref_external, cmp_neg_ref_external;
    logic adc_pos_ref_external, adc_neg_ref_external, port_a_pin_three_ext_pos;
    logic [3:0] ladder_tap_code;
    logic [5:0] ladder_tap_numerator, ladder_tap_denominator, vin1 = 0, vin2 = 0;
    logic [1:0] port_a_pin_two_func;
    int err_count = 0, checks_done = 0;

    vrsc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fast_internal_oscillator(fast_internal_oscillator),
        .cmp1_result(cmp1_result), .cmp2_result(cmp2_result),
        .ladder_power_enable(ladder_power_enable),
        .ladder_pin_output_enable(ladder_pin_output_enable),
        .ladder_range_low(ladder_range_low), .ladder_source_external(ladder_source_external),
        .ladder_tap_code(ladder_tap_code), .ladder_tap_numerator(ladder_tap_numerator),
        .ladder_tap_denominator(ladder_tap_denominator),
        .ladder_current_enable(ladder_current_enable),
        .adjustable_reference_clamp(adjustable_reference_clamp),
        .fixed_reference_on(fixed_reference_on),
        .cmp1_adjustable_route(cmp1_adjustable_route),
        .cmp2_adjustable_route(cmp2_adjustable_route),
        .cmp_pos_ref_external(cmp_pos_ref_external),
        .cmp_neg_ref_external(cmp_neg_ref_external),
        .adc_pos_ref_external(adc_pos_ref_external),
        .adc_neg_ref_external(adc_neg_ref_external),
        .port_a_pin_two_func(port_a_pin_two_func),
        .port_a_pin_three_ext_pos(port_a_pin_three_ext_pos));
    vrsc_analog_model i_ana (.osc_req(osc_req), .vin1(vin1), .vin2(vin2),
        .route1(cmp1_adjustable_route), .route2(cmp2_adjustable_route),
        .live(ladder_power_enable & ~adjustable_reference_clamp), .num(ladder_tap_numerator),
        .den(ladder_tap_denominator), .osc(fast_internal_oscillator), .res1(cmp1_result),
        .res2(cmp2_result));

    always #10 pclk = ~pclk;

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1 && ++i < 20);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        if (i >= 20) chk("pready", 1, 0);
    endtask

    // Outputs follow a write one edge after the write takes effect.
    task settle;
        @(posedge pclk);
        #1;
    endtask

    task t_reset;
        for (int j = 0; j < 4; j++)
        begin
            apb(0, 12'(j * 4), 0);
            chk("reset read", 0, rd);
        end
        chk("reset outputs", 14'h1220, {ladder_power_enable, adjustable_reference_clamp,
            ladder_tap_numerator, ladder_tap_denominator});
        $display("t_reset done");
    endtask

    task t_ref;
        static logic [7:0] tv[4] = '{8'hFF, 8'h2F, 8'h90, 8'h45};
        foreach (tv[j])
        begin
            apb(1, 12'h000, {24'h0, tv[j]});
            settle;
            chk("power", tv[j][7], ladder_power_enable);
            chk("pin oe", tv[j][6], ladder_pin_output_enable);
            chk("range", tv[j][5], ladder_range_low);
            chk("source", tv[j][4], ladder_source_external);
            chk("tap", tv[j][3:0], ladder_tap_code);
            chk("num", tv[j][3:0] + (tv[j][5] ? 0 : 8), ladder_tap_numerator);
            chk("den", tv[j][5] ? 24 : 32, ladder_tap_denominator);
            apb(0, 12'h000, 0);
            chk("readback", tv[j], rd);
        end
        $display("t_ref done");
    endtask

    task t_sel;
        apb(1, 12'h000, 32'hB7);
        for (int k = 0; k < 8; k++)
        begin
            apb(1, 12'h008, {31'h0, k[2]});
            apb(1, 12'h004, {26'h0, k[1], k[0], 4'h0});
            settle;
            chk("route1", k[1], cmp1_adjustable_route);
            chk("route2", k[0], cmp2_adjustable_route);
            chk("current", (k[1] | k[0]) & k[2], ladder_current_enable);
            chk("clamp", !k[2], adjustable_reference_clamp);
            chk("fixed on", k[2], fixed_reference_on);
            chk("ladder", 7'h77, {ladder_power_enable, ladder_range_low,
                ladder_source_external, ladder_tap_code});
        end
        $display("t_sel done");
    endtask

    task t_route;
        for (int k = 0; k < 16; k++)
        begin
            apb(1, 12'h00C, {30'h0, k[3], k[2]});
            apb(1, 12'h000, {25'h0, k[0], 1'b0, k[1], 4'h0});
            settle;
            chk("cmp pos", k[1], cmp_pos_ref_external);
            chk("cmp neg", k[1] & (k[3] | !k[0]), cmp_neg_ref_external);
            chk("adc", {k[3], k[2]}, {adc_neg_ref_external, adc_pos_ref_external});
            chk("pin two", (k[3] | (k[1] & !k[0])) ? 2 : k[0], port_a_pin_two_func);
            chk("pin three", k[2] | k[1], port_a_pin_three_ext_pos);
        end
        $display("t_route done");
    endtask

    task t_status;
        apb(1, 12'h004, 0);
        apb(1, 12'h008, 0);
        vin1 <= 63;
        osc_req <= 1;
        // Settling wait before the fixed reference is used.
        repeat (4) @(posedge pclk);
        apb(0, 12'h010, 0);
        chk("status", 32'h0D, rd);
        chk("status error", 0, err);
        vin1 <= 0;
        vin2 <= 63;
        osc_req <= 0;
        apb(1, 12'h010, 32'hFF);
        repeat (4) @(posedge pclk);
        apb(0, 12'h010, 0);
        chk("status", 32'h02, rd);
        apb(0, 12'h020, 0);
        chk("unmapped error", 1, err);
        chk("unmapped data", 0, rd);
        $display("t_status done");
    endtask

    task print_verdict;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        err_count++;
        print_verdict;
    end

    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        t_reset;
        t_ref;
        t_sel;
        t_route;
        t_status;
        print_verdict;
    end
endmodule // voltage_ref_select_ctrl_tb

// [verification/vrsc_analog_model.sv]
`timescale 1ns/1ns

// Comparators sample an input level in 64ths of the supply against the routed reference.
module vrsc_analog_model
#(
    parameter FIXED_LEVEL = 12'h00C
)
(
    input logic osc_req,
    input logic [5:0] vin1,
    input logic [5:0] vin2,
    input logic route1,
    input logic route2,
    input logic live,
    input logic [5:0] num,
    input logic [5:0] den,
    output logic osc,
    output logic res1,
    output logic res2
);
    logic [11:0] adj;
    // Ladder tap level, ground when clamped.
    assign adj = live ? ({6'h00, num} * 12'h040) / {6'h00, den} : 12'h000;
    assign osc = osc_req;
    assign res1 = {6'h00, vin1} > (route1 ? adj : FIXED_LEVEL);
    assign res2 = {6'h00, vin2} > (route2 ? adj : FIXED_LEVEL);
endmodule // vrsc_analog_model

// [verification/vrsc_chk.sv]
`timescale 1ns/1ns

module vrsc_chk
#(
    parameter TAP_WIDTH = 4
)
(
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic pready,
    input logic fast_internal_oscillator,
    input logic ladder_power_enable,
    input logic ladder_pin_output_enable,
    input logic ladder_range_low,
    input logic ladder_source_external,
    input logic [TAP_WIDTH-1:0] ladder_tap_code,
    input logic [5:0] ladder_tap_numerator,
    input logic [5:0] ladder_tap_denominator,
    input logic ladder_current_enable,
    input logic adjustable_reference_clamp,
    input logic fixed_reference_on,
    input logic cmp1_adjustable_route,
    input logic cmp2_adjustable_route,
    input logic cmp_neg_ref_external,
    input logic adc_pos_ref_external,
    input logic adc_neg_ref_external,
    input logic [1:0] port_a_pin_two_func,
    input logic port_a_pin_three_ext_pos
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic acc;
    logic neg_pin;
    assign acc = psel && penable && pready;
    assign neg_pin = adc_neg_ref_external || (ladder_source_external && !ladder_pin_output_enable);
    chk_pready_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    chk_write_power: assert property (acc && pwrite && paddr == 12'h000 |-> ##2 ladder_power_enable == $past(pwdata[7], 2))
        else $error("power enable does not follow write");
    chk_low_tap: assert property (ladder_range_low |-> ladder_tap_numerator == 6'(ladder_tap_code) && ladder_tap_denominator == 6'h18)
        else $error("low range tap wrong");
    chk_high_tap: assert property (!ladder_range_low |-> ladder_tap_numerator == 6'(ladder_tap_code) + 6'h08 && ladder_tap_denominator == 6'h20)
        else $error("high range tap wrong");
    chk_current_or: assert property (ladder_current_enable == ((cmp1_adjustable_route || cmp2_adjustable_route) && !adjustable_reference_clamp))
        else $error("ladder current wrong");
    chk_fixed_on: assert property (!adjustable_reference_clamp |-> fixed_reference_on)
        else $error("fixed reference off while enabled");
    chk_osc_fixed: assert property (fast_internal_oscillator [*4] |-> fixed_reference_on)
        else $error("fixed reference off while oscillator runs");
    chk_cmp_neg: assert property (cmp_neg_ref_external == (ladder_source_external && (adc_neg_ref_external || !ladder_pin_output_enable)))
        else $error("comparator negative reference wrong");
    chk_pin_two: assert property (port_a_pin_two_func == (neg_pin ? 2'h2 : {1'b0, ladder_pin_output_enable}))
        else $error("pin two function wrong");
    chk_pin_three: assert property (port_a_pin_three_ext_pos == (adc_pos_ref_external || ladder_source_external))
        else $error("pin three function wrong");
    cover property (acc && pwrite);
    cover property (fixed_reference_on && adjustable_reference_clamp);
    cover property (port_a_pin_two_func == 2'h2);
endmodule // vrsc_chk

bind vrsc_top vrsc_chk #(.TAP_WIDTH(TAP_WIDTH)) i_chk (.*);
